// *** hw/srcfg_pkg.sv ***
// Package of the switch radio configuration register bank.
// Assumes a 32-bit classic Wishbone slave with byte-wide registers in the low lane.
package srcfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SRCFG_INPUT_SETUP_ADDR  = 8'h00;
    localparam logic [7:0] SRCFG_RADIO_SETUP_ADDR  = 8'h04;
    localparam logic [7:0] SRCFG_BLE_TX_SETUP_ADDR = 8'h08;
    localparam logic [7:0] SRCFG_ACTIVE_INPUT_ADDR = 8'h0c;
    localparam logic [7:0] SRCFG_ACTIVE_RADIO_ADDR = 8'h10;
    localparam logic [7:0] SRCFG_ACTIVE_BLE_ADDR   = 8'h14;
    localparam logic [7:0] SRCFG_STATUS_ADDR       = 8'h18;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] SRCFG_REG_RESET        = 8'h00;
    localparam logic [7:0] SRCFG_INPUT_SETUP_MASK = 8'h07;
    localparam logic [7:0] SRCFG_RADIO_SETUP_MASK = 8'h11;
    localparam logic [7:0] SRCFG_BLE_TX_MASK      = 8'h7f;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SRCFG_SPRING_DIR_BIT   = 0;
    localparam int SRCFG_AUX_ONE_DIS_BIT  = 1;
    localparam int SRCFG_AUX_TWO_DIS_BIT  = 2;
    localparam int SRCFG_PROTOCOL_BIT     = 0;
    localparam int SRCFG_TX_POWER_BIT     = 4;
    localparam int SRCFG_CHAN_LSB         = 0;
    localparam int SRCFG_CHAN_MSB         = 2;
    localparam int SRCFG_AIR_RATE_BIT     = 3;
    localparam int SRCFG_BEACON_BIT       = 4;
    localparam int SRCFG_IDENTITY_BIT     = 5;
    localparam int SRCFG_REPORT_ENC_BIT   = 6;

    // ------------------------------------------------------------------
    // Channel plan codes and channel set encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] SRCFG_PLAN_ADV       = 3'h0;
    localparam logic [2:0] SRCFG_PLAN_DATA_3    = 3'h1;
    localparam logic [2:0] SRCFG_PLAN_DATA_2    = 3'h2;
    localparam logic [2:0] SRCFG_PLAN_DATA_1    = 3'h3;
    localparam logic [2:0] SRCFG_PLAN_BOTH_3    = 3'h4;
    localparam logic [2:0] SRCFG_PLAN_BOTH_2    = 3'h5;
    localparam logic [2:0] SRCFG_PLAN_BOTH_1    = 3'h6;
    localparam logic [2:0] SRCFG_PLAN_RESERVED  = 3'h7;
    // Channel set output: bit 2 = custom channels, bits 1:0 = count of channels.
    localparam logic [2:0] SRCFG_CHSET_ADV      = 3'h3;
    localparam logic [2:0] SRCFG_CHSET_CUSTOM_3 = 3'h7;
    localparam logic [2:0] SRCFG_CHSET_CUSTOM_2 = 3'h6;
    localparam logic [2:0] SRCFG_CHSET_CUSTOM_1 = 3'h5;

    // ------------------------------------------------------------------
    // Physical values
    // ------------------------------------------------------------------
    localparam logic [7:0] SRCFG_POWER_HIGH_DBM = 8'h04;
    localparam logic [7:0] SRCFG_POWER_LOW_DBM  = 8'h00;
    localparam logic [1:0] SRCFG_RATE_1M        = 2'h1;
    localparam logic [1:0] SRCFG_RATE_2M        = 2'h2;
    localparam logic [4:0] SRCFG_PERIOD_20_MS   = 5'h14;
    localparam logic [4:0] SRCFG_PERIOD_10_MS   = 5'h0a;

    // ------------------------------------------------------------------
    // Actuation sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        SRCFG_IDLE,
        SRCFG_ACTIVE
    } srcfg_state_type;

endpackage : srcfg_pkg

// *** hw/srcfg_regs.sv ***
// Configuration register bank of a pushbutton radio transmitter and its decoding.
// Assumes a classic Wishbone master on clk_i and an actuation sequencer driving
// the spring and auxiliary input levels and the actuation start and end pulses.
//
// Functional notes
// - Direction select zero: spring away from board is press, towards is release.
// - Direction select one: mapping inverted, towards is press, away is release.
// - Input setup bit 1 set: first auxiliary input reads as unconnected.
// - Input setup bit 2 set: second auxiliary input unconnected; clear means enabled.
// - All three configuration registers reset to zero.
// - Radio setup bit 0 chooses BLE when zero, ZGP when one.
// - Radio setup bit 4 chooses plus four dBm when zero, zero dBm when one.
// - Default channel plan sends all telegrams on the three advertising channels.
// - Plan codes 1-6 use the custom channel registers instead.
// - Plan codes 1-3 custom data only, 4-6 custom both, 7 reserved.
// - Air rate bit zero gives 1 Mbit/s, one gives 2 Mbit/s.
// - Beacon period bit zero gives 20 ms, one gives 10 ms.
// - Identity mode zero uses static address, one a resolvable private address.
// - Report encoding zero is standard, one uses user-defined command values.
// - BLE transmit fields affect BLE telegrams only, never ZGP.
// - Air rate bit 3, period bit 4, identity bit 5, encoding bit 6, bit 7 reserved.
`timescale 1ns/10ps

module srcfg_regs
    import srcfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        act_start_i,
    input  wire logic        act_end_i,
    input  wire logic        spring_away_i,
    input  wire logic        spring_towards_i,
    input  wire logic        aux_one_i,
    input  wire logic        aux_two_i,
    output logic             act_busy_o,
    output logic             press_o,
    output logic             release_o,
    output logic             aux_one_o,
    output logic             aux_two_o,
    output logic             proto_zgp_o,
    output logic      [7:0]  tx_power_dbm_o,
    output logic      [2:0]  data_chset_o,
    output logic      [2:0]  comm_chset_o,
    output logic             plan_reserved_o,
    output logic      [1:0]  air_rate_o,
    output logic      [4:0]  beacon_period_ms_o,
    output logic             rpa_mode_o,
    output logic             user_encoding_o
);

    // ------------------------------------------------------------------
    // Channel plan decode
    // ------------------------------------------------------------------
    // Returns {data set, commissioning set}; reserved code falls back to advertising.
    function automatic logic [5:0] srcfg_plan(input logic [2:0] code);
        logic [5:0] r;
        r = {SRCFG_CHSET_ADV, SRCFG_CHSET_ADV};
        unique case (code)
            SRCFG_PLAN_ADV:      r = {SRCFG_CHSET_ADV, SRCFG_CHSET_ADV};
            SRCFG_PLAN_DATA_3:   r = {SRCFG_CHSET_CUSTOM_3, SRCFG_CHSET_ADV};
            SRCFG_PLAN_DATA_2:   r = {SRCFG_CHSET_CUSTOM_2, SRCFG_CHSET_ADV};
            SRCFG_PLAN_DATA_1:   r = {SRCFG_CHSET_CUSTOM_1, SRCFG_CHSET_ADV};
            SRCFG_PLAN_BOTH_3:   r = {SRCFG_CHSET_CUSTOM_3, SRCFG_CHSET_CUSTOM_3};
            SRCFG_PLAN_BOTH_2:   r = {SRCFG_CHSET_CUSTOM_2, SRCFG_CHSET_CUSTOM_2};
            SRCFG_PLAN_BOTH_1:   r = {SRCFG_CHSET_CUSTOM_1, SRCFG_CHSET_CUSTOM_1};
            SRCFG_PLAN_RESERVED: r = {SRCFG_CHSET_ADV, SRCFG_CHSET_ADV};
        endcase
        return r;
    endfunction : srcfg_plan

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]      input_setup_ff,  nxt_input_setup;
    logic [7:0]      radio_setup_ff,  nxt_radio_setup;
    logic [7:0]      ble_tx_ff,       nxt_ble_tx;
    logic [7:0]      act_input_ff,    nxt_act_input;
    logic [7:0]      act_radio_ff,    nxt_act_radio;
    logic [7:0]      act_ble_ff,      nxt_act_ble;
    srcfg_state_type state_ff,        nxt_state;
    logic [31:0]     dat_ff,          nxt_dat;
    logic            ack_ff,          nxt_ack;
    logic            press_ff,        nxt_press;
    logic            release_ff,      nxt_release;
    logic            aux_one_ff,      nxt_aux_one;
    logic            aux_two_ff,      nxt_aux_two;
    logic            zgp_ff,          nxt_zgp;
    logic [7:0]      power_ff,        nxt_power;
    logic [2:0]      data_ch_ff,      nxt_data_ch;
    logic [2:0]      comm_ch_ff,      nxt_comm_ch;
    logic            plan_rsv_ff,     nxt_plan_rsv;
    logic [1:0]      rate_ff,         nxt_rate;
    logic [4:0]      period_ff,       nxt_period;
    logic            rpa_ff,          nxt_rpa;
    logic            user_enc_ff,     nxt_user_enc;

    // ------------------------------------------------------------------
    // Bus slave and actuation capture
    // ------------------------------------------------------------------
    always_comb begin
        logic       req;
        logic       wr;
        logic [7:0] wbyte;
        req             = wb_cyc_i && wb_stb_i && !ack_ff;
        wr              = req && wb_we_i && wb_sel_i[0];
        wbyte           = wb_dat_i[7:0];
        nxt_input_setup = input_setup_ff;
        nxt_radio_setup = radio_setup_ff;
        nxt_ble_tx      = ble_tx_ff;
        nxt_ack         = req;
        nxt_dat         = 32'h0000_0000;
        if (wr) begin
            unique case (wb_adr_i[7:0])
                // Reserved bits are dropped so that they always read as zero.
                SRCFG_INPUT_SETUP_ADDR:  nxt_input_setup = wbyte & SRCFG_INPUT_SETUP_MASK;
                SRCFG_RADIO_SETUP_ADDR:  nxt_radio_setup = wbyte & SRCFG_RADIO_SETUP_MASK;
                SRCFG_BLE_TX_SETUP_ADDR: nxt_ble_tx      = wbyte & SRCFG_BLE_TX_MASK;
                default: ;
            endcase
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i[7:0])
                SRCFG_INPUT_SETUP_ADDR:  nxt_dat[7:0] = input_setup_ff;
                SRCFG_RADIO_SETUP_ADDR:  nxt_dat[7:0] = radio_setup_ff;
                SRCFG_BLE_TX_SETUP_ADDR: nxt_dat[7:0] = ble_tx_ff;
                SRCFG_ACTIVE_INPUT_ADDR: nxt_dat[7:0] = act_input_ff;
                SRCFG_ACTIVE_RADIO_ADDR: nxt_dat[7:0] = act_radio_ff;
                SRCFG_ACTIVE_BLE_ADDR:   nxt_dat[7:0] = act_ble_ff;
                SRCFG_STATUS_ADDR:       nxt_dat[0]   = (state_ff == SRCFG_ACTIVE);
                default: ;
            endcase
        end
        nxt_state     = state_ff;
        nxt_act_input = act_input_ff;
        nxt_act_radio = act_radio_ff;
        nxt_act_ble   = act_ble_ff;
        unique case (state_ff)
            SRCFG_IDLE: begin
                if (act_start_i) begin
                    nxt_state     = SRCFG_ACTIVE;
                    nxt_act_input = input_setup_ff;
                    nxt_act_radio = radio_setup_ff;
                    nxt_act_ble   = ble_tx_ff;
                end
            end
            SRCFG_ACTIVE: begin
                if (act_end_i) begin
                    nxt_state = SRCFG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_setup_ff <= SRCFG_REG_RESET;
            radio_setup_ff <= SRCFG_REG_RESET;
            ble_tx_ff      <= SRCFG_REG_RESET;
            act_input_ff   <= SRCFG_REG_RESET;
            act_radio_ff   <= SRCFG_REG_RESET;
            act_ble_ff     <= SRCFG_REG_RESET;
            state_ff       <= SRCFG_IDLE;
            ack_ff         <= 1'b0;
            dat_ff         <= 32'h0000_0000;
        end else begin
            input_setup_ff <= nxt_input_setup;
            radio_setup_ff <= nxt_radio_setup;
            ble_tx_ff      <= nxt_ble_tx;
            act_input_ff   <= nxt_act_input;
            act_radio_ff   <= nxt_act_radio;
            act_ble_ff     <= nxt_act_ble;
            state_ff       <= nxt_state;
            ack_ff         <= nxt_ack;
            dat_ff         <= nxt_dat;
        end
    end

    // ------------------------------------------------------------------
    // Decoding of the captured configuration
    // ------------------------------------------------------------------
    always_comb begin
        logic       inv;
        logic       ble;
        logic [5:0] plan;
        inv          = act_input_ff[SRCFG_SPRING_DIR_BIT];
        ble          = !act_radio_ff[SRCFG_PROTOCOL_BIT];
        plan         = srcfg_plan(act_ble_ff[SRCFG_CHAN_MSB:SRCFG_CHAN_LSB]);
        nxt_press    = inv ? spring_towards_i : spring_away_i;
        nxt_release  = inv ? spring_away_i : spring_towards_i;
        nxt_aux_one  = aux_one_i && !act_input_ff[SRCFG_AUX_ONE_DIS_BIT];
        nxt_aux_two  = aux_two_i && !act_input_ff[SRCFG_AUX_TWO_DIS_BIT];
        nxt_zgp      = !ble;
        nxt_power    = act_radio_ff[SRCFG_TX_POWER_BIT] ? SRCFG_POWER_LOW_DBM
                                                        : SRCFG_POWER_HIGH_DBM;
        // BLE-only fields fall back to their defaults while ZGP is selected.
        nxt_data_ch  = ble ? plan[5:3] : SRCFG_CHSET_ADV;
        nxt_comm_ch  = ble ? plan[2:0] : SRCFG_CHSET_ADV;
        nxt_plan_rsv = ble && (act_ble_ff[SRCFG_CHAN_MSB:SRCFG_CHAN_LSB]
                               == SRCFG_PLAN_RESERVED);
        nxt_rate     = (ble && act_ble_ff[SRCFG_AIR_RATE_BIT]) ? SRCFG_RATE_2M
                                                               : SRCFG_RATE_1M;
        nxt_period   = (ble && act_ble_ff[SRCFG_BEACON_BIT]) ? SRCFG_PERIOD_10_MS
                                                             : SRCFG_PERIOD_20_MS;
        nxt_rpa      = ble && act_ble_ff[SRCFG_IDENTITY_BIT];
        nxt_user_enc = ble && act_ble_ff[SRCFG_REPORT_ENC_BIT];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            press_ff    <= 1'b0;
            release_ff  <= 1'b0;
            aux_one_ff  <= 1'b0;
            aux_two_ff  <= 1'b0;
            zgp_ff      <= 1'b0;
            power_ff    <= SRCFG_POWER_HIGH_DBM;
            data_ch_ff  <= SRCFG_CHSET_ADV;
            comm_ch_ff  <= SRCFG_CHSET_ADV;
            plan_rsv_ff <= 1'b0;
            rate_ff     <= SRCFG_RATE_1M;
            period_ff   <= SRCFG_PERIOD_20_MS;
            rpa_ff      <= 1'b0;
            user_enc_ff <= 1'b0;
        end else begin
            press_ff    <= nxt_press;
            release_ff  <= nxt_release;
            aux_one_ff  <= nxt_aux_one;
            aux_two_ff  <= nxt_aux_two;
            zgp_ff      <= nxt_zgp;
            power_ff    <= nxt_power;
            data_ch_ff  <= nxt_data_ch;
            comm_ch_ff  <= nxt_comm_ch;
            plan_rsv_ff <= nxt_plan_rsv;
            rate_ff     <= nxt_rate;
            period_ff   <= nxt_period;
            rpa_ff      <= nxt_rpa;
            user_enc_ff <= nxt_user_enc;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o           = dat_ff;
    assign wb_ack_o           = ack_ff;
    assign act_busy_o         = (state_ff == SRCFG_ACTIVE);
    assign press_o            = press_ff;
    assign release_o          = release_ff;
    assign aux_one_o          = aux_one_ff;
    assign aux_two_o          = aux_two_ff;
    assign proto_zgp_o        = zgp_ff;
    assign tx_power_dbm_o     = power_ff;
    assign data_chset_o       = data_ch_ff;
    assign comm_chset_o       = comm_ch_ff;
    assign plan_reserved_o    = plan_rsv_ff;
    assign air_rate_o         = rate_ff;
    assign beacon_period_ms_o = period_ff;
    assign rpa_mode_o         = rpa_ff;
    assign user_encoding_o    = user_enc_ff;

endmodule : srcfg_regs

// *** testbench/srcfg_checker.sv ***
// Concurrent checks on the ports of the configuration register bank.
// Assumes a bind from the bench top, one clock and a synchronous reset.
`timescale 1ns/10ps
module srcfg_checker
    import srcfg_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        act_start_i,
    input wire logic        act_end_i,
    input wire logic        spring_away_i,
    input wire logic        spring_towards_i,
    input wire logic        aux_one_i,
    input wire logic        aux_two_i,
    input wire logic        act_busy_o,
    input wire logic        press_o,
    input wire logic        release_o,
    input wire logic        aux_one_o,
    input wire logic        aux_two_o,
    input wire logic        proto_zgp_o,
    input wire logic [7:0]  tx_power_dbm_o,
    input wire logic [2:0]  data_chset_o,
    input wire logic [2:0]  comm_chset_o,
    input wire logic        plan_reserved_o,
    input wire logic [1:0]  air_rate_o,
    input wire logic [4:0]  beacon_period_ms_o,
    input wire logic        rpa_mode_o,
    input wire logic        user_encoding_o
);
    // ------------------------------------------------------------------
    // Shadow of live and captured registers
    // ------------------------------------------------------------------
    logic [23:0] lv_ff, nxt_lv, ac_ff, nxt_ac, ad_ff;
    logic        bz_ff, nxt_bz, run_ff, tk, zg;
    logic [2:0]  pl;
    assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign zg = ad_ff[8];
    assign pl = ad_ff[18:16];
    always_comb begin
        nxt_lv = lv_ff;
        nxt_ac = ac_ff;
        nxt_bz = bz_ff;
        if (tk && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i[7:0])
                SRCFG_INPUT_SETUP_ADDR:  nxt_lv[7:0]   = wb_dat_i[7:0] & SRCFG_INPUT_SETUP_MASK;
                SRCFG_RADIO_SETUP_ADDR:  nxt_lv[15:8]  = wb_dat_i[7:0] & SRCFG_RADIO_SETUP_MASK;
                SRCFG_BLE_TX_SETUP_ADDR: nxt_lv[23:16] = wb_dat_i[7:0] & SRCFG_BLE_TX_MASK;
                default: ;
            endcase
        end
        if (act_start_i && !bz_ff) begin
            nxt_ac = lv_ff;
            nxt_bz = 1'b1;
        end else if (act_end_i && bz_ff) begin
            nxt_bz = 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        lv_ff  <= rst_i ? '0 : nxt_lv;
        ac_ff  <= rst_i ? '0 : nxt_ac;
        ad_ff  <= rst_i ? '0 : ac_ff;
        bz_ff  <= rst_i ? 1'b0 : nxt_bz;
        run_ff <= !rst_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !run_ff);

    ack_lat_a: assert property (tk |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    busy_track_a: assert property (act_busy_o == bz_ff)
        else $error("busy level wrong for start and end history");
    press_map_a: assert property (
        press_o == (ad_ff[0] ? $past(spring_towards_i) : $past(spring_away_i))
        && release_o == (ad_ff[0] ? $past(spring_away_i) : $past(spring_towards_i)))
        else $error("press or release mapping wrong");
    aux_gate_a: assert property (
        aux_one_o == ($past(aux_one_i) && !ad_ff[1])
        && aux_two_o == ($past(aux_two_i) && !ad_ff[2]))
        else $error("auxiliary input gating wrong");
    proto_sel_a: assert property (proto_zgp_o == zg)
        else $error("protocol select wrong");
    power_sel_a: assert property (
        tx_power_dbm_o == (ad_ff[12] ? SRCFG_POWER_LOW_DBM : SRCFG_POWER_HIGH_DBM))
        else $error("transmit power wrong");
    chan_plan_a: assert property (
        data_chset_o[2] == (!zg && pl inside {[3'h1:3'h6]})
        && comm_chset_o[2] == (!zg && pl inside {[3'h4:3'h6]})
        && plan_reserved_o == (!zg && pl == 3'h7))
        else $error("channel plan decode wrong");
    ble_fields_a: assert property (
        air_rate_o == ((!zg && ad_ff[19]) ? SRCFG_RATE_2M : SRCFG_RATE_1M)
        && beacon_period_ms_o == ((!zg && ad_ff[20]) ? SRCFG_PERIOD_10_MS : SRCFG_PERIOD_20_MS)
        && rpa_mode_o == (!zg && ad_ff[21]) && user_encoding_o == (!zg && ad_ff[22]))
        else $error("BLE field decode wrong");
    cover property (act_start_i && act_busy_o);
    cover property (zg && tx_power_dbm_o == SRCFG_POWER_LOW_DBM);
    cover property (plan_reserved_o);
endmodule : srcfg_checker

// *** testbench/srcfg_wb_writer.sv ***
// Classic Wishbone master standing in for the configuration writer.
// Assumes its task is called from one bench process after reset release.
`timescale 1ns/10ps
module srcfg_wb_writer
    import srcfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] adr_o,
    output logic      [31:0] dat_o,
    output logic      [3:0]  sel_o,
    output logic             we_o,
    output logic             cyc_o,
    output logic             stb_o
);
    // ------------------------------------------------------------------
    // Single classic cycle
    // ------------------------------------------------------------------
    initial begin
        {adr_o, dat_o, sel_o, we_o, cyc_o, stb_o} = '0;
    end
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        case (a)
            SRCFG_INPUT_SETUP_ADDR: return d & SRCFG_INPUT_SETUP_MASK;
            SRCFG_RADIO_SETUP_ADDR: return d & SRCFG_RADIO_SETUP_MASK;
            default:                return d & SRCFG_BLE_TX_MASK;
        endcase
    endfunction : legal
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, sel_o} <= {1'b1, 1'b1, w, 4'h1};
        adr_o <= {24'h0, a};
        dat_o <= {24'h0, legal(a, d)};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i[7:0];
        {cyc_o, stb_o} <= 2'h0;
        adr_o <= ~adr_o;
        dat_o <= ~dat_o;
    endtask : xfer
endmodule : srcfg_wb_writer

// *** testbench/tb_top.sv ***
// Self-checking bench for the configuration register bank.
// Assumes the writer model drives the bus and the bench drives actuation.
`timescale 1ns/10ps
module tb_top import srcfg_pkg::*;;
    logic        clk_i, rst_i, act_start_i, act_end_i, wb_we_i, wb_cyc_i, wb_stb_i;
    logic        spring_away_i, spring_towards_i, aux_one_i, aux_two_i, wb_ack_o;
    logic        act_busy_o, press_o, release_o, aux_one_o, aux_two_o, proto_zgp_o;
    logic        plan_reserved_o, rpa_mode_o, user_encoding_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic [7:0]  tx_power_dbm_o, rd;
    logic [4:0]  beacon_period_ms_o;
    logic [3:0]  wb_sel_i;
    logic [2:0]  data_chset_o, comm_chset_o;
    logic [1:0]  air_rate_o;
    int          err_count, samples_checked, cycles;
    srcfg_regs i_srcfg_regs (.*);
    srcfg_wb_writer i_srcfg_wb_writer (.clk_i, .ack_i(wb_ack_o), .dat_i(wb_dat_o),
        .adr_o(wb_adr_i), .dat_o(wb_dat_i), .sel_o(wb_sel_i), .we_o(wb_we_i),
        .cyc_o(wb_cyc_i), .stb_o(wb_stb_i));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [2:0] chs(input logic [2:0] p, input logic comm);
        if (p == 3'h0 || p == 3'h7 || (comm && p < 3'h4)) return SRCFG_CHSET_ADV;
        case ((p - 3'h1) % 3'h3)
            3'h0:    return SRCFG_CHSET_CUSTOM_3;
            3'h1:    return SRCFG_CHSET_CUSTOM_2;
            default: return SRCFG_CHSET_CUSTOM_1;
        endcase
    endfunction : chs
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_srcfg_wb_writer.xfer(1'b1, a, d, rd);
    endtask : wr
    task automatic actuate(input logic [3:0] pins);
        @(posedge clk_i);
        {aux_two_i, aux_one_i, spring_towards_i, spring_away_i} <= pins;
        act_start_i <= 1'b1;
        @(posedge clk_i);
        act_start_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask : actuate
    task automatic stop_act;
        @(posedge clk_i);
        act_end_i <= 1'b1;
        @(posedge clk_i);
        act_end_i <= 1'b0;
    endtask : stop_act
    task automatic give_verdict;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_regs;
        logic [7:0] m [3] = '{SRCFG_INPUT_SETUP_MASK, SRCFG_RADIO_SETUP_MASK, SRCFG_BLE_TX_MASK};
        chk(tx_power_dbm_o, SRCFG_POWER_HIGH_DBM);
        chk(data_chset_o, SRCFG_CHSET_ADV);
        for (int i = 0; i < 4; i++) begin
            i_srcfg_wb_writer.xfer(1'b0, 8'(i == 3 ? 28 : i * 4), 8'h00, rd);
            chk(rd, SRCFG_REG_RESET);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'(i * 4), 8'hff);
            i_srcfg_wb_writer.xfer(1'b0, 8'(i * 4), 8'h00, rd);
            chk(rd, m[i]);
            wr(8'(i * 4), 8'h00);
        end
    endtask : s_regs
    task automatic s_input;
        for (int c = 0; c < 8; c++) begin
            for (int s = 1; s < 3; s++) begin
                wr(SRCFG_INPUT_SETUP_ADDR, 8'(c));
                actuate({2'h3, 2'(s)});
                chk(press_o, c[0] ? s[1] : s[0]);
                chk(release_o, c[0] ? s[0] : s[1]);
                chk({aux_one_o, aux_two_o}, {!c[1], !c[2]});
                stop_act();
            end
        end
    endtask : s_input
    task automatic s_radio;
        logic [3:0] p;
        for (int i = 0; i < 16; i++) begin
            p = 4'(i);
            wr(SRCFG_BLE_TX_SETUP_ADDR, {1'b0, p[0], p[1], p[2], p[3], p[2:0]});
            actuate(4'h0);
            chk(data_chset_o, chs(p[2:0], 1'b0));
            chk(comm_chset_o, chs(p[2:0], 1'b1));
            chk(plan_reserved_o, p[2:0] == 3'h7);
            chk(air_rate_o, p[3] ? SRCFG_RATE_2M : SRCFG_RATE_1M);
            chk(beacon_period_ms_o, p[2] ? SRCFG_PERIOD_10_MS : SRCFG_PERIOD_20_MS);
            chk({rpa_mode_o, user_encoding_o}, {p[1], p[0]});
            stop_act();
        end
        for (int r = 0; r < 4; r++) begin
            wr(SRCFG_RADIO_SETUP_ADDR, {3'h0, r[1], 3'h0, r[0]});
            actuate(4'h0);
            chk(proto_zgp_o, r[0]);
            chk(tx_power_dbm_o, r[1] ? SRCFG_POWER_LOW_DBM : SRCFG_POWER_HIGH_DBM);
            chk(air_rate_o, r[0] ? SRCFG_RATE_1M : SRCFG_RATE_2M);
            chk(data_chset_o, SRCFG_CHSET_ADV);
            chk(plan_reserved_o, !r[0]);
            stop_act();
        end
    endtask : s_radio
    task automatic s_hold;
        actuate(4'h0);
        wr(SRCFG_RADIO_SETUP_ADDR, 8'h00);
        actuate(4'h0);
        chk({act_busy_o, proto_zgp_o}, 8'h3);
        i_srcfg_wb_writer.xfer(1'b0, SRCFG_ACTIVE_RADIO_ADDR, 8'h00, rd);
        chk(rd, SRCFG_RADIO_SETUP_MASK);
        stop_act();
        actuate(4'h0);
        chk(proto_zgp_o, 1'b0);
        stop_act();
    endtask : s_hold
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        {rst_i, act_start_i, act_end_i} = 3'h4;
        {spring_away_i, spring_towards_i, aux_one_i, aux_two_i} = 4'h0;
        {err_count, samples_checked, cycles} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_input();
        s_radio();
        s_hold();
        give_verdict();
    end
endmodule : tb_top
bind srcfg_regs srcfg_checker i_srcfg_checker (.*);
